// ### common/rss_pkg.sv
// Package for the reset source and system integrity status block.
// Assumes a single 250 MHz system clock and an 8-bit register port.
`default_nettype none
package rss_pkg;
   // Clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // Internal reset phase lengths in clock cycles
   localparam logic [12:0] PHASE_SHORT_CYC = 13'h0100;
   localparam logic [12:0] PHASE_LONG_CYC  = 13'h1000;
   // Least reset pin output pulse, in nanoseconds
   localparam int unsigned PIN_OUT_MIN_NS = 20000;
   localparam int unsigned PIN_OUT_MIN_CYC =
      (PIN_OUT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Register offset
   localparam logic [3:0] SICS_OFFSET = 4'h0;
   // Field positions
   localparam int unsigned IRQ_EN_BIT  = 6;
   localparam int unsigned VD_FLAG_BIT = 5;
   localparam int unsigned LVR_BIT     = 4;
   localparam int unsigned LOCK_BIT    = 3;
   localparam int unsigned WDR_BIT     = 0;
   // Reset value of the stored enable bit, and the value of unmapped reads
   localparam logic IRQ_EN_RESET = 1'b0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rss_bus_req_type;

   // Reset cause inputs
   typedef struct packed {
      logic lvd_reset;
      logic wdg_reset;
      logic pin_low;
   } rss_cause_type;

   typedef enum logic [1:0] {
      RSS_ST_RUN   = 2'b00,
      RSS_ST_PHASE = 2'b01
   } rss_state_type;
endpackage : rss_pkg
`default_nettype wire

// ### hdl/rss_pin_stretch.sv
// Open-drain reset pin driver with least output pulse.
// Assumes pin_low_det comes from an asynchronous detector.
`default_nettype none
module rss_pin_stretch (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic pin_low_det,
   input  wire logic hold_low,
   output logic      pin_oe_n,
   output logic      busy
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        seen;
   } rss_ps_type;
   rss_ps_type st_reg;
   rss_ps_type st_next;

   ////////////////////////////////////////////////////////////////////
   // Reload counter on recognition, count down to release
   always_comb begin
      st_next = st_reg;
      // Only a fresh low level or hold_low starts a pulse; our own drive reads low too
      st_next.seen = pin_low_det;
      if ((pin_low_det && !st_reg.seen) || hold_low) begin
         st_next.cnt = 16'(rss_pkg::PIN_OUT_MIN_CYC);
      end else if (st_reg.cnt != 16'h0000) begin
         st_next.cnt = st_reg.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Drive low (enable low) while stretching
   assign busy     = (st_reg.cnt != 16'h0000);
   assign pin_oe_n = ~(busy || hold_low);
endmodule : rss_pin_stretch
`default_nettype wire

// ### hdl/rss_phase_timer.sv
// Internal reset phase timer.
// Assumes sys_rst_req is held high while any reset source is active.
`default_nettype none
module rss_phase_timer (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic sys_rst_req,
   input  wire logic long_phase,
   output logic      in_phase,
   output logic      fetch_vec
);
   typedef struct packed {
      rss_pkg::rss_state_type state;
      logic [12:0]            cnt;
      logic                   fetch;
   } rss_pt_type;
   rss_pt_type st_reg;
   rss_pt_type st_next;

   ////////////////////////////////////////////////////////////////////
   // Phase sequencing: restart on any request, fetch at end
   always_comb begin
      st_next = st_reg;
      st_next.fetch = 1'b0;
      case (st_reg.state)
         rss_pkg::RSS_ST_RUN: begin
            if (sys_rst_req) begin
               st_next.state = rss_pkg::RSS_ST_PHASE;
               st_next.cnt   = 13'h0000;
            end
         end
         rss_pkg::RSS_ST_PHASE: begin
            if (sys_rst_req) begin
               st_next.cnt = 13'h0000;
            end else if (st_reg.cnt == (long_phase ?
                         rss_pkg::PHASE_LONG_CYC - 13'h0001 :
                         rss_pkg::PHASE_SHORT_CYC - 13'h0001)) begin
               st_next.state = rss_pkg::RSS_ST_RUN;
               st_next.fetch = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt + 13'h0001;
            end
         end
         default: begin
            st_next.state = rss_pkg::RSS_ST_PHASE;
            st_next.cnt   = 13'h0000;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= '{rss_pkg::RSS_ST_PHASE, 13'h0000, 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_phase  = (st_reg.state == rss_pkg::RSS_ST_PHASE);
   assign fetch_vec = st_reg.fetch;
endmodule : rss_phase_timer
`default_nettype wire

// ### hdl/rss_top.sv
// Reset sequencing and system integrity status register.
// Assumes the oscillator keeps running in reset and rst is power-on.
//
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none

// Contract
// - Every reset runs an internal phase of 256 or 4096 cycles before fetch.
// - The oscillator is not stopped during the reset phase.
// - The reset pin is an input and an open-drain output with pull-up.
// - A low reset pin is detected without the clock, even in halt.
// - After recognition the pin is driven low for a least pulse time.
// - With bit 6 set, a rise of the voltage flag raises an interrupt.
// - Entering the interrupt routine clears the pending voltage interrupt.
// - Bit 5 is the read-only voltage flag from the supply monitor.
// - Bit 4 is set by a low-voltage reset and cleared by a zero write.
// - Bit 4 stays set through later watchdog or pin resets.
// - Bit 3 is the read-only PLL lock flag, 1 when locked.
// - Bit 0 is set by a watchdog reset, cleared by zero write or LOW_VOLTAGE_DETECTOR reset.
// - The two flags encode pin, watchdog or supply fault as the cause.
module rss_top (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire rss_pkg::rss_bus_req_type bus_req,
   output logic [7:0]                    bus_rdata,
   input  wire rss_pkg::rss_cause_type   cause,
   input  wire logic                     volt_detect_in,
   input  wire logic                     pll_locked_in,
   input  wire logic                     long_phase_sel,
   input  wire logic                     irq_ack,
   output logic                          volt_detect_irq,
   input  wire logic                     reset_pin_in,
   output logic                          reset_pin_out,
   output logic                          reset_pin_oe_n,
   output logic                          osc_enable,
   output logic                          core_reset,
   output logic                          fetch_vector
);
   typedef struct packed {
      logic       irq_en;
      logic       vd_prev;
      logic       irq_pend;
      logic       lvr_flag;
      logic       wdr_flag;
      logic [7:0] rdata;
   } rss_top_type;

   rss_top_type st_reg;
   rss_top_type st_next;
   logic        pin_low_async;
   logic        pin_busy;
   logic        in_phase;
   logic        sys_rst_req;
   logic        pin_low_hold;

   ////////////////////////////////////////////////////////////////////
   // Register image assembled from stored and live bits
   function automatic logic [7:0] sics_image(input rss_top_type s,
                                             input logic vd,
                                             input logic lk);
      logic [7:0] v;
      v = 8'h00;
      v[rss_pkg::IRQ_EN_BIT]  = s.irq_en;
      v[rss_pkg::VD_FLAG_BIT] = vd;
      v[rss_pkg::LVR_BIT]     = s.lvr_flag;
      v[rss_pkg::LOCK_BIT]    = lk;
      v[rss_pkg::WDR_BIT]     = s.wdr_flag;
      return v;
   endfunction : sics_image

   ////////////////////////////////////////////////////////////////////
   // Pin low caught asynchronously, held until a clock edge sees it
   always_ff @(posedge clk_sys or negedge reset_pin_in) begin
      if (!reset_pin_in) begin
         pin_low_async <= 1'b1;
      end else begin
         pin_low_async <= 1'b0;
      end
   end

   // Pin low also resets the core combinationally
   assign pin_low_hold = pin_low_async || cause.pin_low;

   rss_pin_stretch u_pin (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .pin_low_det (pin_low_hold),
      .hold_low    (cause.wdg_reset || cause.lvd_reset),
      .pin_oe_n    (reset_pin_oe_n),
      .busy        (pin_busy)
   );

   assign sys_rst_req = pin_low_hold || pin_busy ||
                        cause.wdg_reset || cause.lvd_reset;

   rss_phase_timer u_phase (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .sys_rst_req (sys_rst_req),
      .long_phase  (long_phase_sel),
      .in_phase    (in_phase),
      .fetch_vec   (fetch_vector)
   );

   ////////////////////////////////////////////////////////////////////
   // Flags, interrupt and register port
   always_comb begin
      logic wr_hit;
      wr_hit  = bus_req.wr && (bus_req.addr == rss_pkg::SICS_OFFSET);
      st_next = st_reg;
      st_next.vd_prev = volt_detect_in;
      // Software writes: enable, and zero-write clears of flags
      if (wr_hit) begin
         st_next.irq_en = bus_req.wdata[rss_pkg::IRQ_EN_BIT];
         if (!bus_req.wdata[rss_pkg::LVR_BIT]) begin
            st_next.lvr_flag = 1'b0;
         end
         if (!bus_req.wdata[rss_pkg::WDR_BIT]) begin
            st_next.wdr_flag = 1'b0;
         end
      end
      // Interrupt pending: ack clears, rise sets and wins
      if (irq_ack) begin
         st_next.irq_pend = 1'b0;
      end
      if (st_reg.irq_en && volt_detect_in && !st_reg.vd_prev) begin
         st_next.irq_pend = 1'b1;
      end
      // Reset sources: set wins over write clear; watchdog leaves bit 4 alone
      if (cause.wdg_reset) begin
         st_next.wdr_flag = 1'b1;
      end
      if (cause.lvd_reset) begin
         st_next.lvr_flag = 1'b1;
         st_next.wdr_flag = 1'b0;
      end
      st_next.rdata = rss_pkg::UNMAPPED_READ;
      if (bus_req.rd) begin
         if (bus_req.addr == rss_pkg::SICS_OFFSET) begin
            // Read-only bits come from live inputs
            st_next.rdata = sics_image(st_reg, volt_detect_in,
                                       pll_locked_in);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= '{rss_pkg::IRQ_EN_RESET, 1'b0, 1'b0, 1'b0, 1'b0,
                     8'h00};
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign bus_rdata       = st_reg.rdata;
   assign volt_detect_irq = st_reg.irq_pend;
   assign reset_pin_out   = 1'b0;
   assign osc_enable      = 1'b1;
   assign core_reset      = in_phase || sys_rst_req;
endmodule : rss_top
`default_nettype wire

// ### sim/rss_monitor.sv
// Port checker for the reset source status block.
// Assumes it is bound onto rss_top and sees only its ports.
`default_nettype none
module rss_monitor (
   input wire logic                     clk_sys,
   input wire logic                     rst,
   input wire rss_pkg::rss_bus_req_type bus_req,
   input wire logic [7:0]               bus_rdata,
   input wire rss_pkg::rss_cause_type   cause,
   input wire logic                     volt_detect_in,
   input wire logic                     long_phase_sel,
   input wire logic                     irq_ack,
   input wire logic                     volt_detect_irq,
   input wire logic                     reset_pin_in,
   input wire logic                     reset_pin_out,
   input wire logic                     reset_pin_oe_n,
   input wire logic                     osc_enable,
   input wire logic                     core_reset,
   input wire logic                     fetch_vector
);
   logic [15:0] low_cnt;
   logic [15:0] ph_cnt;
   logic        int_seen;
   int          ph_len;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Phase length for the selected setting
   assign ph_len = long_phase_sel ? 4096 : 256;
   // Pin-low run length, phase length so far, internal cause seen
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_cnt  <= 16'h0000;
         ph_cnt   <= 16'h0000;
         int_seen <= 1'b0;
      end else begin
         low_cnt  <= reset_pin_oe_n ? 16'h0000 : low_cnt + 16'h0001;
         ph_cnt   <= (core_reset && reset_pin_oe_n) ?
                     ph_cnt + 16'h0001 : 16'h0000;
         int_seen <= !reset_pin_oe_n &&
                     (int_seen || cause.wdg_reset || cause.lvd_reset);
      end
   end
   a_osc_running: assert property (osc_enable)
      else $error("oscillator stopped");
   a_pin_open_drain: assert property (reset_pin_out == 1'b0)
      else $error("reset pin driven high");
   a_pin_async_det: assert property (!reset_pin_in |-> core_reset)
      else $error("low pin did not reset the core");
   a_pin_stretch: assert property ($rose(reset_pin_oe_n) && !int_seen
      |-> low_cnt >= rss_pkg::PIN_OUT_MIN_CYC)
      else $error("pin pulse too short");
   a_fetch_pulse: assert property (fetch_vector |=> !fetch_vector)
      else $error("fetch pulse too long");
   a_phase_len: assert property (fetch_vector |->
      ph_cnt >= ph_len - 1 && ph_cnt <= ph_len + 3)
      else $error("phase length wrong");
   a_rsvd_zero: assert property (bus_req.rd |=>
      bus_rdata[7] == 1'b0 && bus_rdata[2:1] == 2'h0)
      else $error("reserved bits set");
   a_irq_ack_clr: assert property (irq_ack &&
      !(volt_detect_in && !$past(volt_detect_in)) |=> !volt_detect_irq)
      else $error("interrupt not cleared");
   a_irq_cause: assert property ($rose(volt_detect_irq) |->
      $past(volt_detect_in) && !$past(volt_detect_in, 2))
      else $error("interrupt without flag");
   c_fetch: cover property (fetch_vector);
   c_irq: cover property ($rose(volt_detect_irq));
   c_stretch: cover property ($rose(reset_pin_oe_n));
endmodule : rss_monitor
`default_nettype wire

// ### sim/rss_pin_model.sv
// External reset circuit on the open-drain reset pin.
// Assumes a weak pull-up on the pin and the system clock.
`default_nettype none
module rss_pin_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [15:0] pulse_len,
   input  wire logic        oe_n,
   output logic             ext_low,
   output logic             pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_reg;
   // Holds the pin low for the commanded number of cycles
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) cnt_reg <= 16'h0000;
      else if (start) cnt_reg <= pulse_len;
      else if (cnt_reg != 16'h0000) cnt_reg <= cnt_reg - 16'h0001;
   end
   // Wired level: any party pulls low, else the pull-up wins
   assign ext_low = (cnt_reg != 16'h0000);
   assign pin_level = ~(ext_low | ~oe_n);
endmodule : rss_pin_model
`default_nettype wire

// ### sim/rss_top_test.sv
// Testbench for the reset source status block.
// Assumes rss_top, rss_monitor and rss_pin_model compiled first.
`default_nettype none
module rss_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk_sys, rst, irq_ack, wdg_c, lvd_c, pstart;
   logic                     volt_detect_in, pll_locked_in, long_phase_sel;
   logic                     volt_detect_irq, reset_pin_out, reset_pin_oe_n;
   logic                     osc_enable, core_reset, fetch_vector;
   logic                     reset_pin_in, ext_low;
   logic [7:0]               bus_rdata;
   rss_pkg::rss_bus_req_type bus_req;
   rss_pkg::rss_cause_type   cause;
   int                       num_errors, samples_checked;
   // Design, pin model and cause levels
   assign cause = {lvd_c, wdg_c, ext_low};
   rss_top u_rss_top (.clk_sys, .rst, .bus_req, .bus_rdata, .cause,
      .volt_detect_in, .pll_locked_in, .long_phase_sel, .irq_ack,
      .volt_detect_irq, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n,
      .osc_enable, .core_reset, .fetch_vector);
   rss_pin_model u_rss_pin_model (.clk_sys, .rst, .start(pstart),
      .pulse_len(16'h000a), .oe_n(reset_pin_oe_n), .ext_low,
      .pin_level(reset_pin_in));
   // Clock
   always begin
      #2 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task automatic ok(input logic c);
      samples_checked++;
      if (c !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t ns check failed", $time);
      end
   endtask : ok
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
      @(posedge clk_sys);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      ok((bus_rdata & m) === e);
   endtask : rd
   // Kind 0 pin, 1 watchdog, 2 supply fault, 3 none; measures phases
   task automatic do_reset(input int kind, input logic lg);
      int lo, ph, n;
      lo = 0;
      ph = 0;
      n = lg ? 4096 : 256;
      @(posedge clk_sys);
      long_phase_sel <= lg;
      {pstart, wdg_c, lvd_c} <= {kind == 0, kind == 1, kind == 2};
      @(posedge clk_sys);
      {pstart, wdg_c, lvd_c} <= 3'h0;
      for (int i = 0; i < 20000 && fetch_vector !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
         if (reset_pin_oe_n === 1'b0) lo++;
         else if (core_reset === 1'b1) ph++;
      end
      if (kind == 0) ok(lo >= rss_pkg::PIN_OUT_MIN_CYC);
      ok(ph >= n - 3 && ph <= n + 3);
      ok(fetch_vector === 1'b1);
   endtask : do_reset
   task automatic t_regs;
      @(posedge clk_sys);
      {volt_detect_in, pll_locked_in} <= 2'h3;
      repeat (3) @(posedge clk_sys);
      rd(4'h0, 8'h28, 8'hae);
      wr(4'h0, 8'hff);
      {volt_detect_in, pll_locked_in} <= 2'h0;
      repeat (3) @(posedge clk_sys);
      rd(4'h0, 8'h40, 8'hee);
      rd(4'h3, 8'h00, 8'hff);
   endtask : t_regs
   task automatic t_irq;
      wr(4'h0, 8'h40);
      volt_detect_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      ok(volt_detect_irq === 1'b1);
      @(posedge clk_sys);
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      #1;
      ok(volt_detect_irq === 1'b0);
      wr(4'h0, 8'h00);
      volt_detect_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      volt_detect_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      ok(volt_detect_irq === 1'b0);
      @(posedge clk_sys);
      volt_detect_in <= 1'b0;
   endtask : t_irq
   task automatic t_wdg;
      do_reset(1, 1'b0);
      rd(4'h0, 8'h01, 8'h11);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00, 8'h11);
      do_reset(1, 1'b0);
   endtask : t_wdg
   task automatic t_lvd;
      do_reset(2, 1'b0);
      rd(4'h0, 8'h10, 8'h11);
      do_reset(1, 1'b0);
      rd(4'h0, 8'h11, 8'h11);
   endtask : t_lvd
   task automatic t_pin;
      do_reset(0, 1'b1);
      rd(4'h0, 8'h11, 8'h11);
      wr(4'h0, 8'h00);
      do_reset(0, 1'b0);
      rd(4'h0, 8'h00, 8'h11);
   endtask : t_pin
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////
   // Main sequence
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      {irq_ack, wdg_c, lvd_c, pstart} = 4'h0;
      {volt_detect_in, pll_locked_in, long_phase_sel} = 3'h0;
      bus_req = '0;
      num_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      do_reset(3, 1'b0);
      t_regs();
      t_irq();
      t_wdg();
      t_lvd();
      t_pin();
      print_verdict();
   end
   // Watchdog on a hung run
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end
endmodule : rss_top_test
bind rss_top rss_monitor u_rss_monitor (.clk_sys, .rst, .bus_req,
   .bus_rdata, .cause, .volt_detect_in, .long_phase_sel, .irq_ack,
   .volt_detect_irq, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n,
   .osc_enable, .core_reset, .fetch_vector);
`default_nettype wire
